// File: rtl/vsb_pkg.sv
// holds command codes, register indices, reset values and protection levels
// of the per-page output voltage setpoint bank; shared by both rtl modules
package vsb_pkg;

  localparam int VW = 16;
  localparam int CW = 8;
  localparam int LW = 3;
  localparam int NREG = 6;

  localparam logic [CW-1:0] CMD_MODE = 8'h20;
  localparam logic [CW-1:0] CMD_NOM = 8'h21;
  localparam logic [CW-1:0] CMD_TRIM = 8'h22;
  localparam logic [CW-1:0] CMD_CAL = 8'h23;
  localparam logic [CW-1:0] CMD_CEIL = 8'h24;
  localparam logic [CW-1:0] CMD_MHI = 8'h25;
  localparam logic [CW-1:0] CMD_MLO = 8'h26;

  localparam logic [2:0] IDX_NOM = 3'h0;
  localparam logic [2:0] IDX_TRIM = 3'h1;
  localparam logic [2:0] IDX_CAL = 3'h2;
  localparam logic [2:0] IDX_CEIL = 3'h3;
  localparam logic [2:0] IDX_MHI = 3'h4;
  localparam logic [2:0] IDX_MLO = 3'h5;

  localparam logic [VW-1:0] RST_NOM = 16'h0384;
  localparam logic [VW-1:0] RST_TRIM = 16'h0000;
  localparam logic [VW-1:0] RST_CAL = 16'h0000;
  localparam logic [VW-1:0] RST_CEIL = 16'h0BEA;
  localparam logic [VW-1:0] RST_MHI = 16'h03B1;
  localparam logic [VW-1:0] RST_MLO = 16'h0357;
  localparam logic [NREG-1:0][VW-1:0] RST_VALS =
    {RST_MLO, RST_MHI, RST_CEIL, RST_CAL, RST_TRIM, RST_NOM};

  localparam logic [7:0] MODE_VAL = 8'h40;
  localparam logic [LW-1:0] SP_LEN = 3'h2;
  localparam logic [LW-1:0] MODE_LEN = 3'h1;

  localparam logic [7:0] WP_NONE = 8'h00;
  localparam logic [7:0] WP_DMA = 8'h02;
  localparam logic [7:0] WP_VCMD = 8'h20;

  typedef enum logic [1:0] {
    VSB_SEL_NOM = 2'b00,
    VSB_SEL_MLO = 2'b01,
    VSB_SEL_MHI = 2'b10
  } vsb_sel_t;

endpackage : vsb_pkg

// File: rtl/vsb_target_calc.sv
// holds the per-page target arithmetic: active setpoint plus trim plus
// offset, clamped to zero and the ceiling; purely combinational
`timescale 1ns/1ps
module vsb_target_calc (
  input wire logic [1:0] sel_in,
  input wire logic [vsb_pkg::VW-1:0] nom_in,
  input wire logic [vsb_pkg::VW-1:0] mhi_in,
  input wire logic [vsb_pkg::VW-1:0] mlo_in,
  input wire logic [vsb_pkg::VW-1:0] trim_in,
  input wire logic [vsb_pkg::VW-1:0] cal_in,
  input wire logic [vsb_pkg::VW-1:0] ceil_in,
  output logic [vsb_pkg::VW-1:0] target_out
);
  import vsb_pkg::*;

  logic [VW-1:0] act;
  logic signed [VW+1:0] sum;

  always_comb begin
    case (sel_in)
      VSB_SEL_MHI: act = mhi_in;
      VSB_SEL_MLO: act = mlo_in;
      default: act = nom_in;
    endcase
    sum = $signed({2'b00, act}) + $signed({{2{trim_in[VW-1]}}, trim_in})
      + $signed({{2{cal_in[VW-1]}}, cal_in});
    if (sum < 0) begin
      target_out = '0;
    end else if (sum > $signed({2'b00, ceil_in})) begin
      target_out = ceil_in;
    end else begin
      target_out = sum[VW-1:0];
    end
  end

endmodule : vsb_target_calc

// File: rtl/vsb_setpoint_bank.sv
// holds the paged output voltage setpoint bank with its command port and
// the registered regulation targets, one per page
// assumes one command per cycle at most, from a bus front end in this clock
//
// Summary of operation
// - nominal setpoint at 21h, used in nominal
// - nominal setpoint resets to 0384h
// - signed trim at 22h, resets zero, added
// - signed calibration offset at 23h, added
// - ceiling at 24h, target never exceeds it
// - ceiling resets to 0BEAh
// - upper margin at 25h, used in margin high
// - upper margin resets to 3B1h
// - lower margin at 26h, used in margin low
// - lower margin resets to 357h
// - two data bytes, all bits read/write
// - protect level 20h passes only nominal writes
// - mode query returns 40h, direct 1mV
`timescale 1ns/1ps
module vsb_setpoint_bank #(
  parameter int PAGES = 2,
  parameter int PAGE_W = 1
) (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic CMD_VALID_IN,
  input wire logic CMD_WRITE_IN,
  input wire logic [vsb_pkg::CW-1:0] CMD_CODE_IN,
  input wire logic [PAGE_W-1:0] CMD_PAGE_IN,
  input wire logic [vsb_pkg::LW-1:0] CMD_LEN_IN,
  input wire logic [vsb_pkg::VW-1:0] CMD_WDATA_IN,
  input wire logic [7:0] WP_LEVEL_IN,
  input wire logic [2*PAGES-1:0] OP_SEL_IN,
  output logic CMD_ACK_OUT,
  output logic CMD_REJECT_OUT,
  output logic [vsb_pkg::VW-1:0] CMD_RDATA_OUT,
  output logic [PAGES*vsb_pkg::VW-1:0] TARGET_OUT
);
  import vsb_pkg::*;

  logic [VW-1:0] regs [PAGES][NREG];
  logic [VW-1:0] next_regs [PAGES][NREG];
  logic next_ack;
  logic next_reject;
  logic [VW-1:0] next_rdata;
  logic [PAGES*VW-1:0] next_target;
  logic [CW-1:0] offs;
  logic [2:0] idx;
  logic is_sp;
  logic page_bad;
  logic wr_allowed;

  assign offs = CMD_CODE_IN - CMD_NOM;
  assign idx = offs[2:0];
  assign is_sp = (CMD_CODE_IN >= CMD_NOM) && (CMD_CODE_IN <= CMD_MLO);
  assign page_bad = int'(CMD_PAGE_IN) >= PAGES;

  // unknown protection levels are treated as locking everything here
  always_comb begin
    if (WP_LEVEL_IN == WP_NONE) begin
      wr_allowed = 1'b1;
    end else if (WP_LEVEL_IN == WP_VCMD || WP_LEVEL_IN == WP_DMA) begin
      wr_allowed = (idx == IDX_NOM);
    end else begin
      wr_allowed = 1'b0;
    end
  end

  always_comb begin
    next_regs = regs;
    next_ack = 1'b0;
    next_reject = 1'b0;
    next_rdata = CMD_RDATA_OUT;
    if (CMD_VALID_IN) begin
      next_ack = 1'b1;
      next_rdata = '0;
      if (CMD_CODE_IN == CMD_MODE) begin
        if (CMD_WRITE_IN || CMD_LEN_IN != MODE_LEN) begin
          next_reject = 1'b1;
        end else begin
          next_rdata = {8'h00, MODE_VAL};
        end
      end else if (!is_sp || page_bad || CMD_LEN_IN != SP_LEN) begin
        next_reject = 1'b1;
      end else if (CMD_WRITE_IN) begin
        if (wr_allowed) begin
          next_regs[CMD_PAGE_IN][idx] = CMD_WDATA_IN;
        end else begin
          next_reject = 1'b1;
        end
      end else begin
        next_rdata = regs[CMD_PAGE_IN][idx];
      end
    end
  end

  for (genvar p = 0; p < PAGES; p++) begin : g_page
    vsb_target_calc u_calc (
      .sel_in(OP_SEL_IN[2*p +: 2]),
      .nom_in(regs[p][IDX_NOM]),
      .mhi_in(regs[p][IDX_MHI]),
      .mlo_in(regs[p][IDX_MLO]),
      .trim_in(regs[p][IDX_TRIM]),
      .cal_in(regs[p][IDX_CAL]),
      .ceil_in(regs[p][IDX_CEIL]),
      .target_out(next_target[p*VW +: VW])
    );
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      for (int p = 0; p < PAGES; p++) begin
        for (int i = 0; i < NREG; i++) begin
          regs[p][i] <= RST_VALS[i];
        end
      end
      CMD_ACK_OUT <= 1'b0;
      CMD_REJECT_OUT <= 1'b0;
      CMD_RDATA_OUT <= '0;
      TARGET_OUT <= '0;
    end else begin
      regs <= next_regs;
      CMD_ACK_OUT <= next_ack;
      CMD_REJECT_OUT <= next_reject;
      CMD_RDATA_OUT <= next_rdata;
      TARGET_OUT <= next_target;
    end
  end

  sequence s_mode_read;
    CMD_VALID_IN && !CMD_WRITE_IN && CMD_CODE_IN == CMD_MODE
      && CMD_LEN_IN == MODE_LEN;
  endsequence

  sequence s_prot_trim_wr;
    CMD_VALID_IN && CMD_WRITE_IN && WP_LEVEL_IN == WP_VCMD
      && CMD_CODE_IN == CMD_TRIM && CMD_PAGE_IN == '0
      && CMD_LEN_IN == SP_LEN;
  endsequence

  sequence s_prot_nom_wr;
    CMD_VALID_IN && CMD_WRITE_IN && WP_LEVEL_IN == WP_VCMD
      && CMD_CODE_IN == CMD_NOM && CMD_PAGE_IN == '0
      && CMD_LEN_IN == SP_LEN;
  endsequence

  sequence s_ok_page0_wr;
    CMD_VALID_IN && CMD_WRITE_IN && WP_LEVEL_IN == WP_NONE && is_sp
      && CMD_PAGE_IN == '0 && CMD_LEN_IN == SP_LEN;
  endsequence

  a_nom_reset: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    $past(RESET_IN) |-> regs[0][IDX_NOM] == RST_NOM)
    else $error("nominal setpoint wrong after reset");

  a_trim_reset: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    $past(RESET_IN) |-> regs[0][IDX_TRIM] == RST_TRIM
      && regs[0][IDX_CAL] == RST_CAL)
    else $error("trim or offset not zero after reset");

  a_ceil_reset: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    $past(RESET_IN) |-> regs[0][IDX_CEIL] == RST_CEIL)
    else $error("ceiling wrong after reset");

  a_mhi_reset: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    $past(RESET_IN) |-> regs[0][IDX_MHI] == RST_MHI)
    else $error("upper margin wrong after reset");

  a_mlo_reset: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    $past(RESET_IN) |-> regs[0][IDX_MLO] == RST_MLO)
    else $error("lower margin wrong after reset");

  a_mode_read: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    s_mode_read |=> CMD_ACK_OUT && !CMD_REJECT_OUT
      && CMD_RDATA_OUT == {8'h00, MODE_VAL})
    else $error("mode query answer wrong");

  a_wp_block: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    s_prot_trim_wr |=> CMD_REJECT_OUT
      && regs[0][IDX_TRIM] == $past(regs[0][IDX_TRIM]))
    else $error("protected trim write not rejected");

  a_wp_nom_ok: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    s_prot_nom_wr |=> !CMD_REJECT_OUT
      && regs[0][IDX_NOM] == $past(CMD_WDATA_IN))
    else $error("nominal write refused under protection");

  a_len_reject: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    CMD_VALID_IN && is_sp && CMD_LEN_IN != SP_LEN |=> CMD_ACK_OUT
      && CMD_REJECT_OUT)
    else $error("wrong byte count accepted");

  a_write_stores: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    s_ok_page0_wr |=> regs[0][$past(idx)] == $past(CMD_WDATA_IN)
      ##1 TARGET_OUT[VW-1:0] <= $past(regs[0][IDX_CEIL]))
    else $error("write not stored or target above ceiling");

  a_target_ceiling: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    !$past(RESET_IN) |-> TARGET_OUT[VW-1:0]
      <= $past(regs[0][IDX_CEIL]))
    else $error("target above ceiling");

  a_target_sum: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    OP_SEL_IN[1:0] == VSB_SEL_NOM && regs[0][IDX_TRIM] == '0
      && regs[0][IDX_CAL] == '0 && regs[0][IDX_NOM] <= regs[0][IDX_CEIL]
      |=> TARGET_OUT[VW-1:0] == $past(regs[0][IDX_NOM]))
    else $error("nominal target not passed through");

  a_mode_ro: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    CMD_VALID_IN && CMD_WRITE_IN && CMD_CODE_IN == CMD_MODE
      |=> CMD_ACK_OUT && CMD_REJECT_OUT)
    else $error("mode write not rejected");

  // any level other than the three known ones locks the whole bank
  a_wp_lock: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    CMD_VALID_IN && CMD_WRITE_IN && is_sp && WP_LEVEL_IN != WP_NONE
      && WP_LEVEL_IN != WP_VCMD && WP_LEVEL_IN != WP_DMA
      |=> CMD_ACK_OUT && CMD_REJECT_OUT)
    else $error("write passed a full lock");

  a_ack_answer: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    !$past(RESET_IN) |-> CMD_ACK_OUT == $past(CMD_VALID_IN))
    else $error("command answer missing or spurious");

  if (PAGES > 1) begin : g_iso
    a_page_isolate: assert property (@(posedge CLK_IN)
      disable iff (RESET_IN)
      s_ok_page0_wr |=> regs[1][$past(idx)] == $past(regs[1][idx]))
      else $error("write leaked into another page");
  end

endmodule : vsb_setpoint_bank

// File: bench/vsb_host_model.sv
// host-side command master for the paged setpoint bank
// assumes the bank registers its answer on the taking edge; it is read at the next falling edge
`timescale 1ns/1ps
module vsb_host_model (
  input wire logic clk_in,
  input wire logic ack_in,
  input wire logic reject_in,
  input wire logic [vsb_pkg::VW-1:0] rdata_in,
  output logic valid_out,
  output logic write_out,
  output logic [vsb_pkg::CW-1:0] code_out,
  output logic [0:0] page_out,
  output logic [vsb_pkg::LW-1:0] len_out,
  output logic [vsb_pkg::VW-1:0] wdata_out
);
  import vsb_pkg::*;

  initial begin
    valid_out = 1'b0;
    write_out = 1'b0;
    code_out = 8'h00;
    page_out = 1'b0;
    len_out = 3'h0;
    wdata_out = 16'h0000;
  end

  // one request per call; data lines turn over once released
  task xfer(input logic w, input logic [7:0] c, input logic [0:0] p,
            input logic [2:0] l, input logic [15:0] d, output logic a,
            output logic r, output logic [15:0] q);
    @(negedge clk_in);
    valid_out = 1'b1;
    write_out = w;
    code_out = c;
    page_out = p;
    len_out = l;
    wdata_out = d;
    @(negedge clk_in);
    a = ack_in;
    r = reject_in;
    q = rdata_in;
    valid_out = 1'b0;
    wdata_out = ~d;
    code_out = ~c;
  endtask : xfer
endmodule : vsb_host_model

// File: bench/vsb_setpoint_bank_tb.sv
// self-checking bench for the paged setpoint bank
// assumes the host model drives all command inputs on falling edges
`timescale 1ns/1ps
module vsb_setpoint_bank_tb;
  import vsb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] wp = 8'h00;
  logic [3:0] op_sel = 4'h0;
  logic valid, cmd_wr, ack, rej;
  logic [7:0] code;
  logic [0:0] page;
  logic [2:0] len;
  logic [15:0] wdata, rdata;
  logic [31:0] target;
  int failures = 0;
  int n_tests = 0;

  always #2 clk = ~clk;

  vsb_host_model host_u (.clk_in(clk), .ack_in(ack), .reject_in(rej),
    .rdata_in(rdata), .valid_out(valid), .write_out(cmd_wr),
    .code_out(code), .page_out(page), .len_out(len), .wdata_out(wdata));

  vsb_setpoint_bank #(.PAGES(2), .PAGE_W(1)) dut_u (.CLK_IN(clk),
    .RESET_IN(rst), .CMD_VALID_IN(valid), .CMD_WRITE_IN(cmd_wr),
    .CMD_CODE_IN(code), .CMD_PAGE_IN(page), .CMD_LEN_IN(len),
    .CMD_WDATA_IN(wdata), .WP_LEVEL_IN(wp), .OP_SEL_IN(op_sel),
    .CMD_ACK_OUT(ack), .CMD_REJECT_OUT(rej), .CMD_RDATA_OUT(rdata),
    .TARGET_OUT(target));

  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task cmd(input logic w, input logic [7:0] c, input logic [0:0] p,
           input logic [2:0] l, input logic [15:0] d, input logic erj,
           input logic [15:0] eq);
    logic a, r;
    logic [15:0] q;
    host_u.xfer(w, c, p, l, d, a, r, q);
    chk("ack", {15'h0000, a}, 16'h0001);
    chk("reject", {15'h0000, r}, {15'h0000, erj});
    chk("rdata", q, eq);
  endtask : cmd

  task wr(input logic [7:0] c, input logic [0:0] p, input logic [15:0] d,
          input logic erj);
    cmd(1'b1, c, p, SP_LEN, d, erj, 16'h0000);
  endtask : wr

  task rd(input logic [7:0] c, input logic [0:0] p, input logic [15:0] e);
    cmd(1'b0, c, p, SP_LEN, 16'h0000, 1'b0, e);
  endtask : rd

  task tgt(input int p, input logic [15:0] e);
    repeat (2) @(negedge clk);
    chk("target", target[16*p +: 16], e);
  endtask : tgt

  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    #20000;
    failures++;
    test_done;
  end

  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < NREG; i++) begin
        rd(8'(CMD_NOM + i), p[0:0], RST_VALS[i]);
      end
    end
    cmd(1'b0, CMD_MODE, 1'b0, MODE_LEN, 16'h0000, 1'b0, 16'h0040);
    tgt(0, RST_NOM);
    $display("test reset done");
    wr(CMD_TRIM, 1'b1, 16'hFFFF, 1'b0);
    rd(CMD_TRIM, 1'b1, 16'hFFFF);
    rd(CMD_TRIM, 1'b0, RST_TRIM);
    wr(CMD_TRIM, 1'b1, 16'hFFF6, 1'b0);
    wr(CMD_CAL, 1'b1, 16'h0014, 1'b0);
    tgt(1, 16'd910);
    op_sel = 4'b1000;
    tgt(1, 16'd955);
    tgt(0, RST_NOM);
    op_sel = 4'b0100;
    tgt(1, 16'd865);
    wr(CMD_CEIL, 1'b1, 16'h0300, 1'b0);
    tgt(1, 16'h0300);
    wr(CMD_CAL, 1'b1, 16'hFC00, 1'b0);
    tgt(1, 16'h0000);
    $display("test target done");
    wp = WP_VCMD;
    wr(CMD_NOM, 1'b0, 16'h03E8, 1'b0);
    rd(CMD_NOM, 1'b0, 16'h03E8);
    for (int i = 1; i < NREG; i++) begin
      wr(8'(CMD_NOM + i), 1'b0, 16'h0100, 1'b1);
      rd(8'(CMD_NOM + i), 1'b0, RST_VALS[i]);
    end
    wp = WP_NONE;
    cmd(1'b0, CMD_NOM, 1'b0, 3'h1, 16'h0000, 1'b1, 16'h0000);
    wr(CMD_MLO, 1'b0, 16'h0BEA, 1'b0);
    rd(CMD_MLO, 1'b0, 16'h0BEA);
    repeat (2) @(negedge clk);
    chk("rdata hold", rdata, 16'h0BEA);
    $display("test protect done");
    wp = WP_DMA;
    wr(CMD_NOM, 1'b1, 16'h0320, 1'b0);
    rd(CMD_NOM, 1'b1, 16'h0320);
    wr(CMD_CEIL, 1'b1, 16'h0100, 1'b1);
    rd(CMD_CEIL, 1'b1, 16'h0300);
    wp = 8'h80;
    wr(CMD_NOM, 1'b1, 16'h0100, 1'b1);
    rd(CMD_NOM, 1'b1, 16'h0320);
    wp = WP_NONE;
    cmd(1'b1, CMD_MODE, 1'b0, MODE_LEN, 16'h0041, 1'b1, 16'h0000);
    cmd(1'b0, CMD_MODE, 1'b0, MODE_LEN, 16'h0000, 1'b0, 16'h0040);
    cmd(1'b0, 8'h27, 1'b0, SP_LEN, 16'h0000, 1'b1, 16'h0000);
    op_sel = 4'b0011;
    tgt(0, 16'h03E8);
    $display("test levels done");
    test_done;
  end
endmodule : vsb_setpoint_bank_tb
